// ### logic/rssu_pkg.sv
// ************************************************************
// ramp start sync constants
// ************************************************************
package rssu_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	localparam int NUM_DEFER = 4;

	// ************************************************************
	// register addresses
	// ************************************************************
	localparam logic [ADDR_W-1:0] ADDR_SYNC_CONFIG = 7'h02;
	localparam logic [ADDR_W-1:0] ADDR_PULSE_EXT = 7'h11;
	localparam logic [ADDR_W-1:0] ADDR_TRIG_DELAY = 7'h13;
	localparam logic [ADDR_W-1:0] ADDR_TARGET_POSITION = 7'h37;
	localparam logic [ADDR_W-1:0] ADDR_MAX_VELOCITY = 7'h24;
	localparam logic [ADDR_W-1:0] ADDR_RAMP_PROFILE = 7'h20;
	localparam logic [ADDR_W-1:0] ADDR_GEARING = 7'h12;
	localparam logic [ADDR_W-1:0] ADDR_SYNC_STATUS = 7'h7F;
	// deferred register order follows the enable switch bits 0..3
	localparam logic [ADDR_W-1:0] DEFER_ADDR [NUM_DEFER] = '{
		ADDR_TARGET_POSITION, ADDR_MAX_VELOCITY, ADDR_RAMP_PROFILE, ADDR_GEARING};

	// ************************************************************
	// sync_config fields
	// ************************************************************
	localparam int CFG_EN_LSB = 0;
	localparam int CFG_EN_W = 5;
	localparam int CFG_EN_SHADOW = 4;
	localparam int CFG_TEV_LSB = 5;
	localparam int CFG_TEV_W = 4;
	localparam int TEV_EXT = 0;
	localparam int TEV_TARGET = 1;
	localparam int TEV_VELOCITY = 2;
	localparam int TEV_POSCOMP = 3;
	localparam int CFG_POL = 9;
	localparam int CFG_IMMEDIATE = 10;
	localparam logic [DATA_W-1:0] CFG_MASK = 32'h0000_07FF;

	// ************************************************************
	// reset values and counts
	// ************************************************************
	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CNT_ONE = 32'h0000_0001;
	localparam logic [CFG_TEV_W-1:0] TEV_NONE = 4'h0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_PEND_LSB = 1;
	localparam int STAT_OUT_ACTIVE = 5;
endpackage : rssu_pkg

// ### logic/rssu_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// start pin synchroniser and active-edge detector
// ************************************************************
module rssu_pin_sync (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic pinIn,
	input wire logic polHigh,
	output logic edgePulse
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// meta_reg feeds only sync_reg
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// idle line sits high, so reset there to avoid a false edge after release
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			meta_reg <= pinIn;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// transition into the active state, never the level
	assign edgePulse = polHigh ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg);
endmodule : rssu_pin_sync
`default_nettype wire

// ### logic/rssu_core.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - all-zero trigger selection: no start signal generated or processed.
// - selection bit 0 clear: internal triggers only, START pin drives each start.
// - selection bit 0 set: START pin is input, its active edge triggers.
// - bits 1..3 select at-target, at-velocity and position-compare events as triggers.
// - any mix of triggers accepted; any one starts the delay.
// - with no deferral switch, register writes apply at once.
// - switches 0..3 defer target, velocity, profile and gearing writes to next start.
// - switch 4 loads the shadow ramp set on each start, internal or external trigger.
// - zero delay gives the start right after the trigger.
// - for a delay of one or more, start comes exactly the programmed delay cycles after a trigger.
// - without bypass, external triggers are delayed like internal ones.
// - bypass bit set: external trigger starts at once, cancelling a running delay.
// - polarity clear: line low active, falling edge in, falling edge out.
// - polarity set: line high active, rising edge in, rising edge out.
// - default output active level lasts one clock cycle.
// - output active level lasts pulse extension plus one cycles.
// - datagram values reach the registers at the end of the datagram.
// - trigger is the transition into the active state, not the level.
// - without bypass, an external trigger during a countdown is ignored.
module rssu_core (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic regWrStrobe,
	input wire logic [rssu_pkg::ADDR_W-1:0] regWrAddr,
	input wire logic [rssu_pkg::DATA_W-1:0] regWrData,
	input wire logic [rssu_pkg::ADDR_W-1:0] regRdAddr,
	output logic [rssu_pkg::DATA_W-1:0] regRdData,
	input wire logic atTargetEvt,
	input wire logic atVelocityEvt,
	input wire logic position_compare_event,
	input wire logic startIn,
	output logic startOut,
	output logic startOe,
	output logic startPulse,
	output logic shadowLoad,
	output logic [rssu_pkg::DATA_W-1:0] target_position,
	output logic [rssu_pkg::DATA_W-1:0] max_velocity,
	output logic [rssu_pkg::DATA_W-1:0] ramp_profile_select,
	output logic [rssu_pkg::DATA_W-1:0] step_gearing_factor
);
	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [rssu_pkg::DATA_W-1:0] syncConfig_reg;
	logic [rssu_pkg::DATA_W-1:0] pulseExt_reg;
	logic [rssu_pkg::DATA_W-1:0] trigDelay_reg;
	logic [rssu_pkg::CFG_EN_W-1:0] cfgEn;
	logic [rssu_pkg::CFG_TEV_W-1:0] cfgTev;
	logic cfgPol;
	logic cfgImm;
	logic anyOn;

	assign cfgEn = syncConfig_reg[rssu_pkg::CFG_EN_LSB +: rssu_pkg::CFG_EN_W];
	assign cfgTev = syncConfig_reg[rssu_pkg::CFG_TEV_LSB +: rssu_pkg::CFG_TEV_W];
	assign cfgPol = syncConfig_reg[rssu_pkg::CFG_POL];
	assign cfgImm = syncConfig_reg[rssu_pkg::CFG_IMMEDIATE];
	assign anyOn = (cfgTev != rssu_pkg::TEV_NONE);

	// writes land on the datagram-end strobe only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			syncConfig_reg <= rssu_pkg::RST_WORD;
			pulseExt_reg <= rssu_pkg::RST_WORD;
			trigDelay_reg <= rssu_pkg::RST_WORD;
		end else if (regWrStrobe) begin
			if (regWrAddr == rssu_pkg::ADDR_SYNC_CONFIG) begin
				syncConfig_reg <= regWrData & rssu_pkg::CFG_MASK;
			end
			if (regWrAddr == rssu_pkg::ADDR_PULSE_EXT) begin
				pulseExt_reg <= regWrData;
			end
			if (regWrAddr == rssu_pkg::ADDR_TRIG_DELAY) begin
				trigDelay_reg <= regWrData;
			end
		end
	end

	// ************************************************************
	// trigger detection
	// ************************************************************
	logic pinEdge;
	logic [rssu_pkg::CFG_TEV_W-1:0] evtNow;
	logic [rssu_pkg::CFG_TEV_W-1:0] evtPrev_reg;
	logic [rssu_pkg::CFG_TEV_W-1:0] evtRise;
	logic extTrig;
	logic intTrig;
	logic bypassHit;

	rssu_pin_sync u_pin_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pinIn(startIn),
		.polHigh(cfgPol),
		.edgePulse(pinEdge)
	);

	assign evtNow = {position_compare_event, atVelocityEvt, atTargetEvt, 1'b0};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			evtPrev_reg <= rssu_pkg::TEV_NONE;
		end else begin
			evtPrev_reg <= evtNow;
		end
	end

	assign evtRise = evtNow & ~evtPrev_reg;
	assign extTrig = cfgTev[rssu_pkg::TEV_EXT] & pinEdge;
	assign intTrig = |(cfgTev & evtRise);
	assign bypassHit = extTrig & cfgImm;

	// ************************************************************
	// delay timer
	// ************************************************************
	logic busy_reg;
	logic busy_next;
	logic [rssu_pkg::DATA_W-1:0] delayCnt_reg;
	logic [rssu_pkg::DATA_W-1:0] delayCnt_next;
	logic startNext;
	logic timerFire;
	logic accept;

	// a countdown swallows every non-bypass trigger until it fires
	assign accept = anyOn & ~busy_reg & (extTrig | intTrig) & ~bypassHit;

	always_comb begin
		busy_next = busy_reg;
		delayCnt_next = delayCnt_reg;
		startNext = 1'b0;
		timerFire = 1'b0;
		if (!anyOn) begin
			busy_next = 1'b0;
			delayCnt_next = rssu_pkg::RST_WORD;
		end else if (bypassHit) begin
			startNext = 1'b1;
			busy_next = 1'b0;
			delayCnt_next = rssu_pkg::RST_WORD;
		end else if (accept) begin
			if (trigDelay_reg <= rssu_pkg::CNT_ONE) begin
				startNext = 1'b1;
				timerFire = 1'b1;
			end else begin
				busy_next = 1'b1;
				delayCnt_next = trigDelay_reg - rssu_pkg::CNT_ONE;
			end
		end else if (busy_reg) begin
			if (delayCnt_reg == rssu_pkg::CNT_ONE) begin
				startNext = 1'b1;
				timerFire = 1'b1;
				busy_next = 1'b0;
			end else begin
				delayCnt_next = delayCnt_reg - rssu_pkg::CNT_ONE;
			end
		end
	end

	logic startPulse_reg;
	logic shadowLoad_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_reg <= 1'b0;
			delayCnt_reg <= rssu_pkg::RST_WORD;
			startPulse_reg <= 1'b0;
			shadowLoad_reg <= 1'b0;
		end else begin
			busy_reg <= busy_next;
			delayCnt_reg <= delayCnt_next;
			startPulse_reg <= startNext;
			shadowLoad_reg <= startNext & cfgEn[rssu_pkg::CFG_EN_SHADOW];
		end
	end

	assign startPulse = startPulse_reg;
	assign shadowLoad = shadowLoad_reg;

	// ************************************************************
	// start pin output
	// ************************************************************
	logic outActive_reg;
	logic outActive_next;
	logic [rssu_pkg::DATA_W-1:0] outCnt_reg;
	logic [rssu_pkg::DATA_W-1:0] outCnt_next;
	logic startOut_reg;

	always_comb begin
		outActive_next = outActive_reg;
		outCnt_next = outCnt_reg;
		if (startNext) begin
			outActive_next = 1'b1;
			outCnt_next = pulseExt_reg;
		end else if (outActive_reg) begin
			if (outCnt_reg == rssu_pkg::RST_WORD) begin
				outActive_next = 1'b0;
			end else begin
				outCnt_next = outCnt_reg - rssu_pkg::CNT_ONE;
			end
		end
	end

	// idle level is the inactive one so the far end sees a clean edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			outActive_reg <= 1'b0;
			outCnt_reg <= rssu_pkg::RST_WORD;
			startOut_reg <= 1'b1;
		end else begin
			outActive_reg <= outActive_next;
			outCnt_reg <= outCnt_next;
			startOut_reg <= cfgPol ? outActive_next : ~outActive_next;
		end
	end

	assign startOut = startOut_reg;
	assign startOe = anyOn & ~cfgTev[rssu_pkg::TEV_EXT];

	// ************************************************************
	// deferred ramp registers
	// ************************************************************
	logic [rssu_pkg::DATA_W-1:0] active_reg [rssu_pkg::NUM_DEFER];
	logic [rssu_pkg::DATA_W-1:0] pendVal_reg [rssu_pkg::NUM_DEFER];
	logic [rssu_pkg::NUM_DEFER-1:0] pending_reg;

	genvar gi;
	generate
		for (gi = 0; gi < rssu_pkg::NUM_DEFER; gi++) begin : g_defer
			logic wrHit;
			assign wrHit = regWrStrobe && (regWrAddr == rssu_pkg::DEFER_ADDR[gi]);
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					active_reg[gi] <= rssu_pkg::RST_WORD;
					pendVal_reg[gi] <= rssu_pkg::RST_WORD;
					pending_reg[gi] <= 1'b0;
				end else begin
					if (startPulse_reg && pending_reg[gi]) begin
						active_reg[gi] <= pendVal_reg[gi];
					end
					if (wrHit && cfgEn[gi]) begin
						pendVal_reg[gi] <= regWrData;
						pending_reg[gi] <= 1'b1;
					end else if (wrHit) begin
						active_reg[gi] <= regWrData;
						pending_reg[gi] <= 1'b0;
					end else if (startPulse_reg) begin
						pending_reg[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	assign target_position = active_reg[0];
	assign max_velocity = active_reg[1];
	assign ramp_profile_select = active_reg[2];
	assign step_gearing_factor = active_reg[3];

	// ************************************************************
	// read port
	// ************************************************************
	logic [rssu_pkg::DATA_W-1:0] rdData_reg;
	logic [rssu_pkg::DATA_W-1:0] rdMux;

	always_comb begin
		rdMux = rssu_pkg::RST_WORD;
		if (regRdAddr == rssu_pkg::ADDR_SYNC_CONFIG) begin
			rdMux = syncConfig_reg;
		end else if (regRdAddr == rssu_pkg::ADDR_PULSE_EXT) begin
			rdMux = pulseExt_reg;
		end else if (regRdAddr == rssu_pkg::ADDR_TRIG_DELAY) begin
			rdMux = trigDelay_reg;
		end else if (regRdAddr == rssu_pkg::ADDR_SYNC_STATUS) begin
			rdMux[rssu_pkg::STAT_BUSY] = busy_reg;
			rdMux[rssu_pkg::STAT_PEND_LSB +: rssu_pkg::NUM_DEFER] = pending_reg;
			rdMux[rssu_pkg::STAT_OUT_ACTIVE] = outActive_reg;
		end
		for (int k = 0; k < rssu_pkg::NUM_DEFER; k++) begin
			if (regRdAddr == rssu_pkg::DEFER_ADDR[k]) begin
				rdMux = active_reg[k];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdData_reg <= rssu_pkg::RST_WORD;
		end else begin
			rdData_reg <= rdMux;
		end
	end

	assign regRdData = rdData_reg;

	// ************************************************************
	// checks
	// ************************************************************
	logic [rssu_pkg::DATA_W-1:0] chkElapsed_reg;
	logic [rssu_pkg::DATA_W-1:0] chkDelay_reg;
	logic chkFromTimer_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			chkElapsed_reg <= rssu_pkg::RST_WORD;
			chkDelay_reg <= rssu_pkg::RST_WORD;
			chkFromTimer_reg <= 1'b0;
		end else begin
			chkFromTimer_reg <= timerFire;
			if (accept) begin
				chkElapsed_reg <= rssu_pkg::CNT_ONE;
				chkDelay_reg <= trigDelay_reg;
			end else if (busy_reg) begin
				chkElapsed_reg <= chkElapsed_reg + rssu_pkg::CNT_ONE;
			end
		end
	end

	property p_no_start_when_off;
		@(posedge clk_sys) disable iff (rst)
		(!anyOn) |=> !startPulse_reg && !busy_reg;
	endproperty
	a_no_start_when_off: assert property (p_no_start_when_off)
		else $error("start produced with no trigger selected");

	property p_pin_direction;
		@(posedge clk_sys) disable iff (rst)
		startOe == (anyOn && !cfgTev[rssu_pkg::TEV_EXT]);
	endproperty
	a_pin_direction: assert property (p_pin_direction)
		else $error("start pin direction wrong");

	property p_delay_exact;
		@(posedge clk_sys) disable iff (rst)
		(startPulse_reg && chkFromTimer_reg && chkDelay_reg >= rssu_pkg::CNT_ONE)
			|-> chkElapsed_reg == chkDelay_reg;
	endproperty
	a_delay_exact: assert property (p_delay_exact)
		else $error("start not after programmed delay");

	property p_bypass_now;
		@(posedge clk_sys) disable iff (rst)
		(extTrig && cfgImm) |=> startPulse_reg && !busy_reg;
	endproperty
	a_bypass_now: assert property (p_bypass_now)
		else $error("bypassed external trigger not immediate");

	property p_ignore_ext_busy;
		@(posedge clk_sys) disable iff (rst)
		(busy_reg && anyOn && extTrig && !cfgImm && delayCnt_reg > rssu_pkg::CNT_ONE)
			|=> busy_reg && delayCnt_reg == $past(delayCnt_reg) - rssu_pkg::CNT_ONE;
	endproperty
	a_ignore_ext_busy: assert property (p_ignore_ext_busy)
		else $error("external trigger disturbed countdown");

	property p_out_one_cycle;
		@(posedge clk_sys) disable iff (rst)
		(startPulse_reg && pulseExt_reg == rssu_pkg::RST_WORD) ##1 !startPulse_reg
			|-> !outActive_reg;
	endproperty
	a_out_one_cycle: assert property (p_out_one_cycle)
		else $error("start output longer than one cycle");

	property p_out_extended;
		@(posedge clk_sys) disable iff (rst)
		(startPulse_reg && pulseExt_reg == rssu_pkg::CNT_ONE) ##1 !startPulse_reg[*2]
			|-> !outActive_reg && $past(outActive_reg, 1) && $past(outActive_reg, 2);
	endproperty
	a_out_extended: assert property (p_out_extended)
		else $error("start output length not extension plus one");

	property p_out_level;
		@(posedge clk_sys) disable iff (rst)
		$past(anyOn) |-> startOut_reg == ($past(cfgPol) ? outActive_reg : !outActive_reg);
	endproperty
	a_out_level: assert property (p_out_level)
		else $error("start output polarity wrong");

	property p_shadow_load;
		@(posedge clk_sys) disable iff (rst)
		shadowLoad_reg == (startPulse_reg && $past(cfgEn[rssu_pkg::CFG_EN_SHADOW]));
	endproperty
	a_shadow_load: assert property (p_shadow_load)
		else $error("shadow load not tied to start");

	property p_deferred_hold;
		@(posedge clk_sys) disable iff (rst)
		(regWrStrobe && regWrAddr == rssu_pkg::ADDR_TARGET_POSITION && cfgEn[0]
			&& !startPulse_reg) |=> target_position == $past(target_position);
	endproperty
	a_deferred_hold: assert property (p_deferred_hold)
		else $error("deferred write applied early");

	property p_immediate_write;
		@(posedge clk_sys) disable iff (rst)
		(regWrStrobe && regWrAddr == rssu_pkg::ADDR_MAX_VELOCITY && !cfgEn[1])
			|=> max_velocity == $past(regWrData);
	endproperty
	a_immediate_write: assert property (p_immediate_write)
		else $error("immediate write not applied");

	property p_pending_apply;
		@(posedge clk_sys) disable iff (rst)
		(startPulse_reg && pending_reg[0]) |=> target_position == $past(pendVal_reg[0]);
	endproperty
	a_pending_apply: assert property (p_pending_apply)
		else $error("pending value not applied at start");
endmodule : rssu_core
`default_nettype wire

// ### tb/rssu_start_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// other controller sharing the start line
// ************************************************************
module rssu_start_peer (
	input wire logic clk_sys,
	input wire logic fire,
	input wire logic [3:0] holdLen,
	input wire logic polHigh,
	input wire logic devDrives,
	output logic driveEn,
	output logic driveVal
);
	logic [3:0] holdCnt = 4'h0;
	// keeps off the line while the device owns it
	assign driveEn = !devDrives;
	// idles inactive so no stray edge reaches the device
	assign driveVal = (holdCnt != 4'h0) ? polHigh : !polHigh;
	always_ff @(posedge clk_sys) begin
		if (fire) begin
			holdCnt <= holdLen;
		end else if (holdCnt != 4'h0) begin
			holdCnt <= holdCnt - 4'h1;
		end
	end
endmodule : rssu_start_peer
`default_nettype wire

// ### tb/ramp_start_sync_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module ramp_start_sync_unit_test;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic wrStb = 1'b0;
	logic [rssu_pkg::ADDR_W-1:0] wrAddr = 7'h00;
	logic [31:0] wrData = 32'h0;
	logic [rssu_pkg::ADDR_W-1:0] rdAddr = 7'h00;
	logic [31:0] rdData;
	logic [2:0] evt = 3'h0;
	logic startOut, startOe, startPulse, shadowLoad, pin, peerEn, peerVal;
	logic peerFire = 1'b0;
	logic pol = 1'b0;
	logic [3:0] hold = 4'h2;
	logic [31:0] act [4];
	logic [31:0] cfg;
	logic [31:0] v [4];
	integer seed = 32'hA92C39F4;
	int fails = 0;
	int testsRun = 0;
	int pulses = 0;
	int shadows = 0;
	int lat, wid, n, x, p0, s0, i, j, b;

	// undriven line would read high; the peer always holds it when the device does not
	assign pin = startOe ? startOut : (peerEn ? peerVal : 1'b1);

	rssu_core i_dut (
		.clk_sys(clk_sys), .rst(rst), .regWrStrobe(wrStb), .regWrAddr(wrAddr),
		.regWrData(wrData), .regRdAddr(rdAddr), .regRdData(rdData),
		.atTargetEvt(evt[0]), .atVelocityEvt(evt[1]), .position_compare_event(evt[2]),
		.startIn(pin), .startOut(startOut), .startOe(startOe), .startPulse(startPulse),
		.shadowLoad(shadowLoad), .target_position(act[0]), .max_velocity(act[1]),
		.ramp_profile_select(act[2]), .step_gearing_factor(act[3])
	);

	rssu_start_peer i_peer (
		.clk_sys(clk_sys), .fire(peerFire), .holdLen(hold), .polHigh(pol),
		.devDrives(startOe), .driveEn(peerEn), .driveVal(peerVal)
	);

	initial begin
		forever #2.5 clk_sys = !clk_sys;
	end

	always @(negedge clk_sys) begin
		if (startPulse === 1'b1) pulses++;
		if (shadowLoad === 1'b1) shadows++;
	end

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic int expLat(input int d);
		return (d == 0) ? 1 : d;
	endfunction : expLat

	function automatic logic [31:0] sel(input int t);
		return 32'h1 << (rssu_pkg::CFG_TEV_LSB + t);
	endfunction : sel

	task automatic wrapUp;
		$display("comparisons %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrapUp

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [rssu_pkg::ADDR_W-1:0] a, input logic [31:0] d);
		wrStb = 1'b1;
		wrAddr = a;
		wrData = d;
		@(negedge clk_sys);
		wrStb = 1'b0;
		@(negedge clk_sys);
	endtask : wr

	task automatic rd(input logic [rssu_pkg::ADDR_W-1:0] a, input logic [31:0] e);
		rdAddr = a;
		@(negedge clk_sys);
		check(rdData, e);
	endtask : rd

	task automatic setup(input logic [31:0] c, input int d, input int e);
		wr(rssu_pkg::ADDR_PULSE_EXT, 32'(e));
		wr(rssu_pkg::ADDR_TRIG_DELAY, 32'(d));
		wr(rssu_pkg::ADDR_SYNC_CONFIG, c);
		pol = c[rssu_pkg::CFG_POL];
		hold = 4'(($random(seed) & 7) + 2);
		repeat (4) @(negedge clk_sys);
		p0 = pulses;
		s0 = shadows;
	endtask : setup

	// source 0 is the peer on the line, 1..3 the internal events
	task automatic fire(input int s, output int l, output int w);
		if (s == 0) peerFire = 1'b1;
		else evt[s-1] = 1'b1;
		l = 1;
		w = 0;
		@(negedge clk_sys);
		if (s == 0) peerFire = 1'b0;
		while (startPulse !== 1'b1 && l < 400) begin
			@(negedge clk_sys);
			l++;
		end
		while (startOut === pol && w < 400) begin
			w++;
			@(negedge clk_sys);
		end
	endtask : fire

	task automatic done(input string nm);
		evt = 3'h0;
		@(negedge clk_sys);
		$display("test %0s done", nm);
	endtask : done

	initial begin
		#100000;
		fails++;
		wrapUp();
	end

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		rd(rssu_pkg::ADDR_SYNC_CONFIG, rssu_pkg::RST_WORD);
		rd(rssu_pkg::ADDR_PULSE_EXT, rssu_pkg::RST_WORD);
		rd(rssu_pkg::ADDR_TRIG_DELAY, rssu_pkg::RST_WORD);
		rd(7'h05, rssu_pkg::RST_WORD);
		rd(rssu_pkg::ADDR_SYNC_STATUS, rssu_pkg::RST_WORD);
		for (j = 0; j < 4; j++) check(act[j], rssu_pkg::RST_WORD);
		check(startOe, 1'b0);
		cfg = $random(seed);
		wr(rssu_pkg::ADDR_SYNC_CONFIG, cfg);
		rd(rssu_pkg::ADDR_SYNC_CONFIG, cfg & rssu_pkg::CFG_MASK);
		cfg = $random(seed);
		wr(rssu_pkg::ADDR_PULSE_EXT, cfg);
		rd(rssu_pkg::ADDR_PULSE_EXT, cfg);
		done("registers");
		setup(32'h0000_0200, 0, 0);
		evt = 3'h7;
		peerFire = 1'b1;
		@(negedge clk_sys);
		peerFire = 1'b0;
		repeat (20) @(negedge clk_sys);
		check(32'(pulses - p0), 0);
		check(startOe, 1'b0);
		done("disabled");
		for (i = 0; i < 15; i++) begin
			n = (i < 3) ? i : ($random(seed) & 32'h1F);
			x = (i < 3) ? 0 : ($random(seed) & 32'h7);
			cfg = sel(1 + i % 3) | ($random(seed) & 32'h3D0);
			setup(cfg, n, x);
			fire(1 + i % 3, lat, wid);
			check(32'(lat), 32'(expLat(n)));
			check(32'(wid), 32'(x + 1));
			check(startOe, 1'b1);
			repeat (n + 8) @(negedge clk_sys);
			check(32'(pulses - p0), 1);
			check(32'(shadows - s0), 32'(cfg[4]));
			evt = 3'h0;
			@(negedge clk_sys);
		end
		done("internal");
		for (i = 0; i < 4; i++) begin
			n = 1 + ($random(seed) & 32'hF);
			setup(sel(0) | (32'(i % 2) << rssu_pkg::CFG_POL), n, 0);
			fire(0, lat, wid);
			check(32'(lat inside {[n + 2:n + 5]}), 1);
			check(startOe, 1'b0);
			check(32'(pulses - p0), 1);
			// peer must release the line before the polarity flips
			repeat (12) @(negedge clk_sys);
		end
		done("external");
		for (b = 0; b < 2; b++) begin
			cfg = sel(0) | sel(3) | (32'(b) << rssu_pkg::CFG_IMMEDIATE);
			setup(cfg | (32'(b) << rssu_pkg::CFG_POL), 20, 0);
			fork
				fire(3, lat, wid);
				begin
					repeat (3) @(negedge clk_sys);
					peerFire = 1'b1;
					@(negedge clk_sys);
					peerFire = 1'b0;
				end
			join
			if (b == 0) check(32'(lat), 32'(expLat(20)));
			else check(32'(lat inside {[5:10]}), 1);
			repeat (30) @(negedge clk_sys);
			check(32'(pulses - p0), 1);
			evt = 3'h0;
			@(negedge clk_sys);
		end
		done("bypass");
		for (b = 0; b < 2; b++) begin
			setup(sel(1) | (b ? 32'h0000_000F : 32'h0), 2, 0);
			for (j = 0; j < 4; j++) begin
				wr(rssu_pkg::DEFER_ADDR[j], $random(seed));
				v[j] = $random(seed);
				wr(rssu_pkg::DEFER_ADDR[j], v[j]);
			end
			for (j = 0; j < 4; j++) begin
				if (b == 0) check(act[j], v[j]);
				else check(32'(act[j] !== v[j]), 1);
			end
			rd(rssu_pkg::ADDR_SYNC_STATUS, b ? 32'h0000_001E : 32'h0000_0000);
			fire(1, lat, wid);
			for (j = 0; j < 4; j++) check(act[j], v[j]);
			evt = 3'h0;
			@(negedge clk_sys);
		end
		done("deferral");
		wrapUp();
	end
endmodule : ramp_start_sync_unit_test
`default_nettype wire
